// *** core/psw_cfg.svh ***
// Constants for the strap configuration and link-wake block.
// Assumes it is included by the package and by the design modules.
`ifndef PSW_CFG_SVH
`define PSW_CFG_SVH

// ****************************************
// Register port
// ****************************************
`define PSW_ADDR_W 4
`define PSW_DATA_W 8
`define PSW_OFS_NODE 4'h0
`define PSW_OFS_PRIO 4'h1
`define PSW_OFS_CTRL 4'h2
`define PSW_OFS_STAT 4'h3

// ****************************************
// Field layout
// ****************************************
`define PSW_NODE_W 6
`define PSW_PRIO_W 4
`define PSW_CTRL_SWRST_BIT 0
`define PSW_STAT_S50_BIT 0
`define PSW_STAT_SEL2_BIT 1
`define PSW_STAT_LPS_BIT 2
`define PSW_STAT_WAKE_BIT 3
`define PSW_STAT_INV_BIT 4

// ****************************************
// Timing counts
// ****************************************
// Link power low samples, in system clock cycles
`define PSW_LPS_LOW_LIMIT 128
// Link-wake half period in system clock cycles
`define PSW_WAKE_HALF_S100 4
`define PSW_WAKE_HALF_S50 2
`define PSW_WAKE_CNT_W 3

`endif

// *** core/psw_pkg.sv ***
// Types of the strap configuration and link-wake block.
// Assumes psw_cfg.svh is on the include path.
`include "psw_cfg.svh"

package psw_pkg;

  typedef enum logic [1:0] {
    PSW_S100 = 2'b01,
    PSW_S50 = 2'b10
  } psw_speed_e;

  typedef enum logic [1:0] {
    PSW_WAKE_IDLE = 2'b01,
    PSW_WAKE_ACTIVE = 2'b10
  } psw_wake_e;

  typedef logic [`PSW_NODE_W-1:0] psw_node_t;
  typedef logic [`PSW_PRIO_W-1:0] psw_prio_t;

endpackage

// *** core/psw_lps_filter.sv ***
// Link power status qualifier.
// Assumes lps_in is synchronous and sample_en is a system clock pulse.
`timescale 1ns/1ps
`include "psw_cfg.svh"

module psw_lps_filter #(
  parameter int LOW_LIMIT = `PSW_LPS_LOW_LIMIT
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic sample_en,
  input wire logic lps_in,
  output logic lps_active
);

  logic [7:0] low_count;

  // ****************************************
  // Low sample counter
  // ****************************************
  // Saturates one past the limit so a long low never wraps to active
  always_ff @(posedge core_clk) begin
    if (reset) begin
      low_count <= 8'h00;
    end else if (sample_en) begin
      if (lps_in) begin
        low_count <= 8'h00;
      end else if (low_count <= 8'(LOW_LIMIT)) begin
        low_count <= low_count + 8'h01;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      lps_active <= 1'b0;
    end else begin
      lps_active <= (low_count <= 8'(LOW_LIMIT));
    end
  end

  AST_LPS_HIGH_ACTIVE: assert property (@(posedge core_clk) disable iff (reset)
    (sample_en && lps_in) |=> ##1 lps_active)
    else $error("lps high sample did not read active");

endmodule

// *** core/psw_top.sv ***
// Strap configuration, transceiver polarity and link-wake logic.
// Assumes core_clk is the reference clock and all inputs are synchronous.
`timescale 1ns/1ps
`include "psw_cfg.svh"

// Function
// - Select speed mode from primary select pin
// - Reset loads node number from six pins
// - Reset loads priority from four pins
// - Software may overwrite loaded fields afterwards
// - Polarity pin inverts all six transceiver pins
// - Active link wake is 4 to 8 MHz square
// - Inactive link wake low, floating in reset
// - Start wake on addressed packet, link inactive
// - Wake stays active until link active
// - Bus reset forces link wake low
// - Link inactive after over 128 low samples
// - System clock is reference divided by two
module psw_top #(
  parameter int LPS_LOW_LIMIT = `PSW_LPS_LOW_LIMIT,
  parameter int WAKE_HALF_S100 = `PSW_WAKE_HALF_S100,
  parameter int WAKE_HALF_S50 = `PSW_WAKE_HALF_S50
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic speed_select_primary,
  input wire logic speed_select_secondary,
  input wire logic node_number_strap_bit0,
  input wire logic node_number_strap_bit1,
  input wire logic node_number_strap_bit2,
  input wire logic node_number_strap_bit3,
  input wire logic node_number_strap_bit4,
  input wire logic node_number_strap_bit5,
  input wire logic priority_strap_bit0,
  input wire logic priority_strap_bit1,
  input wire logic priority_strap_bit2,
  input wire logic priority_strap_bit3,
  input wire logic transceiver_polarity_invert,
  input wire logic tx_data_core,
  input wire logic tx_strobe_core,
  input wire logic oc_enable_core,
  input wire logic ts_enable_core,
  output logic tx_data_out,
  output logic tx_strobe_out,
  output logic open_collector_drive_enable,
  output logic tristate_drive_enable,
  input wire logic rx_data_pin,
  input wire logic rx_strobe_in,
  output logic rx_data_core,
  output logic rx_strobe_core,
  input wire logic link_power_status_input,
  input wire logic link_on_packet_valid,
  input wire logic [`PSW_NODE_W-1:0] link_on_packet_node,
  input wire logic bus_reset_event,
  output logic link_wake_output,
  output logic link_wake_output_oe_n,
  output logic sys_clk_out,
  output logic speed_mode_s50,
  output logic lps_active,
  output logic [`PSW_NODE_W-1:0] node_number_field,
  output logic [`PSW_PRIO_W-1:0] priority_field,
  input wire logic [`PSW_ADDR_W-1:0] reg_addr,
  input wire logic [`PSW_DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [`PSW_DATA_W-1:0] reg_rdata
);

  // ****************************************
  // Declarations
  // ****************************************
  psw_pkg::psw_speed_e speed_mode;
  psw_pkg::psw_wake_e wake_state;
  psw_pkg::psw_wake_e next_wake_state;
  logic sys_en;
  logic sw_full_reset;
  logic strap_load;
  logic link_on_hit;
  logic [`PSW_WAKE_CNT_W-1:0] wave_count;
  logic [`PSW_WAKE_CNT_W-1:0] wave_last;
  logic wave;
  psw_pkg::psw_node_t node_straps;
  psw_pkg::psw_prio_t prio_straps;

  function automatic logic reg_hit(input logic [`PSW_ADDR_W-1:0] addr,
                                   input logic [`PSW_ADDR_W-1:0] ofs);
    reg_hit = (addr == ofs);
  endfunction

  assign node_straps = {node_number_strap_bit5, node_number_strap_bit4,
                        node_number_strap_bit3, node_number_strap_bit2,
                        node_number_strap_bit1, node_number_strap_bit0};
  assign prio_straps = {priority_strap_bit3, priority_strap_bit2,
                        priority_strap_bit1, priority_strap_bit0};
  assign strap_load = reset || sw_full_reset;

  // ****************************************
  // System clock divider
  // ****************************************
  // Same divide in both modes; the reference already differs by mode
  always_ff @(posedge core_clk) begin
    if (reset) begin
      sys_clk_out <= 1'b0;
    end else begin
      sys_clk_out <= !sys_clk_out;
    end
  end

  assign sys_en = sys_clk_out;

  // ****************************************
  // Speed mode
  // ****************************************
  // Board matches the reference to this pin; secondary pin only reported
  always_ff @(posedge core_clk) begin
    if (reset) begin
      speed_mode <= psw_pkg::PSW_S100;
      speed_mode_s50 <= 1'b0;
    end else begin
      speed_mode <= speed_select_primary ? psw_pkg::PSW_S50 : psw_pkg::PSW_S100;
      speed_mode_s50 <= speed_select_primary;
    end
  end

  // ****************************************
  // Software full reset
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (reset) begin
      sw_full_reset <= 1'b0;
    end else begin
      sw_full_reset <= reg_write && reg_hit(reg_addr, `PSW_OFS_CTRL) &&
                       reg_wdata[`PSW_CTRL_SWRST_BIT];
    end
  end

  // ****************************************
  // Node number and priority fields
  // ****************************************
  // Strap load wins over a write in the same cycle
  always_ff @(posedge core_clk) begin
    if (strap_load) begin
      node_number_field <= node_straps;
    end else if (reg_write && reg_hit(reg_addr, `PSW_OFS_NODE)) begin
      node_number_field <= reg_wdata[`PSW_NODE_W-1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (strap_load) begin
      priority_field <= prio_straps;
    end else if (reg_write && reg_hit(reg_addr, `PSW_OFS_PRIO)) begin
      priority_field <= reg_wdata[`PSW_PRIO_W-1:0];
    end
  end

  // ****************************************
  // Transceiver polarity
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (reset) begin
      tx_data_out <= 1'b0;
      tx_strobe_out <= 1'b0;
      open_collector_drive_enable <= 1'b0;
      tristate_drive_enable <= 1'b0;
      rx_data_core <= 1'b0;
      rx_strobe_core <= 1'b0;
    end else begin
      tx_data_out <= tx_data_core ^ transceiver_polarity_invert;
      tx_strobe_out <= tx_strobe_core ^ transceiver_polarity_invert;
      open_collector_drive_enable <= oc_enable_core ^ transceiver_polarity_invert;
      tristate_drive_enable <= ts_enable_core ^ transceiver_polarity_invert;
      rx_data_core <= rx_data_pin ^ transceiver_polarity_invert;
      rx_strobe_core <= rx_strobe_in ^ transceiver_polarity_invert;
    end
  end

  // ****************************************
  // Link power status
  // ****************************************
  psw_lps_filter #(
    .LOW_LIMIT(LPS_LOW_LIMIT)
  ) u_lps_filter (
    .core_clk(core_clk),
    .reset(reset),
    .sample_en(sys_en),
    .lps_in(link_power_status_input),
    .lps_active(lps_active)
  );

  // ****************************************
  // Link-wake state machine
  // ****************************************
  assign link_on_hit = link_on_packet_valid && (link_on_packet_node == node_number_field);

  always_comb begin
    next_wake_state = wake_state;
    unique case (wake_state)
      psw_pkg::PSW_WAKE_IDLE: begin
        if (!bus_reset_event && link_on_hit && !lps_active) begin
          next_wake_state = psw_pkg::PSW_WAKE_ACTIVE;
        end
      end
      psw_pkg::PSW_WAKE_ACTIVE: begin
        if (bus_reset_event) begin
          next_wake_state = psw_pkg::PSW_WAKE_IDLE;
        end else if (lps_active) begin
          next_wake_state = psw_pkg::PSW_WAKE_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      wake_state <= psw_pkg::PSW_WAKE_IDLE;
    end else begin
      wake_state <= next_wake_state;
    end
  end

  // ****************************************
  // Link-wake square wave
  // ****************************************
  // Power-of-two divide gives 6.144 MHz from either reference
  assign wave_last = (speed_mode == psw_pkg::PSW_S50) ?
                     `PSW_WAKE_CNT_W'(WAKE_HALF_S50 - 1) :
                     `PSW_WAKE_CNT_W'(WAKE_HALF_S100 - 1);

  always_ff @(posedge core_clk) begin
    if (reset || wake_state == psw_pkg::PSW_WAKE_IDLE) begin
      wave_count <= '0;
      wave <= 1'b1;
    end else if (sys_en) begin
      if (wave_count >= wave_last) begin
        wave_count <= '0;
        wave <= !wave;
      end else begin
        wave_count <= wave_count + `PSW_WAKE_CNT_W'(1);
      end
    end
  end

  // Low at once when idle; steps only on enables so no half period is cut
  always_ff @(posedge core_clk) begin
    if (reset) begin
      link_wake_output <= 1'b0;
      link_wake_output_oe_n <= 1'b1;
    end else begin
      link_wake_output_oe_n <= 1'b0;
      if (wake_state != psw_pkg::PSW_WAKE_ACTIVE || sys_en) begin
        link_wake_output <= (wake_state == psw_pkg::PSW_WAKE_ACTIVE) && wave;
      end
    end
  end

  // ****************************************
  // Register read port
  // ****************************************
  // Read data stand one cycle only; unmapped reads return zero
  always_ff @(posedge core_clk) begin
    if (reset || !reg_read) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= '0;
      if (reg_hit(reg_addr, `PSW_OFS_NODE)) begin
        reg_rdata[`PSW_NODE_W-1:0] <= node_number_field;
      end
      if (reg_hit(reg_addr, `PSW_OFS_PRIO)) begin
        reg_rdata[`PSW_PRIO_W-1:0] <= priority_field;
      end
      if (reg_hit(reg_addr, `PSW_OFS_STAT)) begin
        reg_rdata[`PSW_STAT_S50_BIT] <= speed_mode_s50;
        reg_rdata[`PSW_STAT_SEL2_BIT] <= speed_select_secondary;
        reg_rdata[`PSW_STAT_LPS_BIT] <= lps_active;
        reg_rdata[`PSW_STAT_WAKE_BIT] <= (wake_state == psw_pkg::PSW_WAKE_ACTIVE);
        reg_rdata[`PSW_STAT_INV_BIT] <= transceiver_polarity_invert;
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_wake_start;
    (wake_state == psw_pkg::PSW_WAKE_IDLE) ##1 (wake_state == psw_pkg::PSW_WAKE_ACTIVE);
  endsequence
  sequence s_wave_high4;
    link_wake_output [*4];
  endsequence

  AST_SPEED_FOLLOWS_PIN: assert property (@(posedge core_clk) disable iff (reset)
    1'b1 |=> (speed_mode_s50 == $past(speed_select_primary)))
    else $error("speed mode does not follow primary select");
  AST_NODE_STRAP_LOAD: assert property (@(posedge core_clk)
    strap_load |=> (node_number_field == $past(node_straps)))
    else $error("node number not loaded from straps");
  AST_PRIO_STRAP_LOAD: assert property (@(posedge core_clk)
    strap_load |=> (priority_field == $past(prio_straps)))
    else $error("priority not loaded from straps");
  AST_NODE_SW_WRITE: assert property (@(posedge core_clk) disable iff (reset)
    (!sw_full_reset && reg_write && reg_addr == `PSW_OFS_NODE) |=>
      (node_number_field == $past(reg_wdata[`PSW_NODE_W-1:0])))
    else $error("node number write lost");
  AST_POLARITY_TX: assert property (@(posedge core_clk) disable iff (reset)
    1'b1 |=> (tx_strobe_out == $past(tx_strobe_core ^ transceiver_polarity_invert)) &&
             (rx_data_core == $past(rx_data_pin ^ transceiver_polarity_invert)))
    else $error("transceiver polarity wrong");
  AST_WAVE_HALF_PERIOD: assert property (@(posedge core_clk)
    disable iff (reset || bus_reset_event || lps_active)
    $rose(link_wake_output) |-> s_wave_high4)
    else $error("link wake half period too short");
  AST_WAKE_IDLE_LOW: assert property (@(posedge core_clk) disable iff (reset)
    (wake_state == psw_pkg::PSW_WAKE_IDLE) |=> (!link_wake_output && !link_wake_output_oe_n))
    else $error("idle link wake not driven low");
  AST_WAKE_FLOAT_RESET: assert property (@(posedge core_clk)
    reset |=> link_wake_output_oe_n)
    else $error("link wake driven during reset");
  AST_WAKE_CAUSE: assert property (@(posedge core_clk) disable iff (reset)
    s_wake_start |-> $past(link_on_hit && !lps_active))
    else $error("link wake started without cause");
  AST_WAKE_HOLD: assert property (@(posedge core_clk) disable iff (reset)
    (wake_state == psw_pkg::PSW_WAKE_ACTIVE && !lps_active && !bus_reset_event) |=>
      (wake_state == psw_pkg::PSW_WAKE_ACTIVE))
    else $error("link wake dropped early");
  AST_BUS_RESET_LOW: assert property (@(posedge core_clk) disable iff (reset)
    bus_reset_event |-> ##2 !link_wake_output)
    else $error("bus reset did not clear link wake");
  AST_SYS_CLK_DIV2: assert property (@(posedge core_clk) disable iff (reset)
    1'b1 |=> (sys_clk_out != $past(sys_clk_out)))
    else $error("system clock not reference over two");

endmodule

// *** testbench/psw_llc_model.sv ***
// Behavioural link layer controller seen from the link-wake pin.
// Assumes it shares clock and reset with the block under test.
`timescale 1ns/1ps

// ****************************************
// Link controller power model
// ****************************************
module psw_llc_model #(
  parameter int WAKE_EDGES = 4
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic sleep_req,
  input wire logic auto_wake,
  input wire logic link_wake_output,
  output logic link_power_status_input
);
  logic last_wake;
  int edges;

  // Steady high while powered; slow to wake, so the wave must persist
  always_ff @(posedge core_clk) begin
    last_wake <= link_wake_output;
    if (reset) begin
      link_power_status_input <= 1'b1;
      edges <= 0;
    end else if (sleep_req) begin
      link_power_status_input <= 1'b0;
      edges <= 0;
    end else if (auto_wake && link_wake_output && !last_wake) begin
      edges <= edges + 1;
      if (edges == WAKE_EDGES - 1) begin
        link_power_status_input <= 1'b1;
      end
    end
  end
endmodule

// *** testbench/testbench.sv ***
// Self-checking bench for the strap and link-wake block.
// Assumes psw_cfg.svh on the include path and the controller model.
`timescale 1ns/1ps
`include "psw_cfg.svh"

// ****************************************
// Bench top
// ****************************************
module testbench;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic speed_select_primary = 1'b0;
  logic [5:0] node_strap = 6'h2A;
  logic [3:0] prio_strap = 4'h9;
  logic transceiver_polarity_invert = 1'b0;
  logic tx_data_core = 1'b0, tx_strobe_core = 1'b0, oc_enable_core = 1'b0;
  logic ts_enable_core = 1'b0, rx_data_pin = 1'b0, rx_strobe_in = 1'b0;
  logic link_on_packet_valid = 1'b0, bus_reset_event = 1'b0;
  logic [5:0] link_on_packet_node = 6'h00;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0, reg_read = 1'b0, sleep_req = 1'b0, auto_wake = 1'b0;
  logic tx_data_out, tx_strobe_out, open_collector_drive_enable, tristate_drive_enable;
  logic rx_data_core, rx_strobe_core, link_power_status_input, link_wake_output;
  logic link_wake_output_oe_n, sys_clk_out, speed_mode_s50, lps_active;
  logic [5:0] node_number_field;
  logic [3:0] priority_field;
  logic [7:0] reg_rdata;
  int n_fail = 0;
  int n_checks = 0;
  int n;

  // 40 MHz stands in for the matching reference clock
  always #12.5 core_clk = ~core_clk;

  // Small low-sample limit keeps the sleep detection short
  psw_top #(.LPS_LOW_LIMIT(4)) dut (
    .core_clk, .reset, .speed_select_primary,
    .speed_select_secondary(1'b0),
    .node_number_strap_bit0(node_strap[0]), .node_number_strap_bit1(node_strap[1]),
    .node_number_strap_bit2(node_strap[2]), .node_number_strap_bit3(node_strap[3]),
    .node_number_strap_bit4(node_strap[4]), .node_number_strap_bit5(node_strap[5]),
    .priority_strap_bit0(prio_strap[0]), .priority_strap_bit1(prio_strap[1]),
    .priority_strap_bit2(prio_strap[2]), .priority_strap_bit3(prio_strap[3]),
    .transceiver_polarity_invert, .tx_data_core, .tx_strobe_core, .oc_enable_core,
    .ts_enable_core, .tx_data_out, .tx_strobe_out, .open_collector_drive_enable,
    .tristate_drive_enable, .rx_data_pin, .rx_strobe_in, .rx_data_core, .rx_strobe_core,
    .link_power_status_input, .link_on_packet_valid, .link_on_packet_node,
    .bus_reset_event, .link_wake_output, .link_wake_output_oe_n, .sys_clk_out,
    .speed_mode_s50, .lps_active, .node_number_field, .priority_field,
    .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata
  );

  psw_llc_model llc (
    .core_clk, .reset, .sleep_req, .auto_wake, .link_wake_output,
    .link_power_status_input
  );

  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    if (n_fail == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1;
    check(reg_rdata, exp);
  endtask

  // Bounded wait on the wake pin (sel 0) or the link status (sel 1)
  task automatic wait_x(input logic sel, input logic v, input int bound);
    int i;
    for (i = 0; i < bound; i++) begin
      @(posedge core_clk);
      #1;
      if ((sel ? lps_active : link_wake_output) === v) return;
    end
    n_fail++;
    finish_test();
  endtask

  task automatic pulse(input int which, input logic [5:0] node);
    @(posedge core_clk);
    if (which == 0) link_on_packet_valid <= 1'b1;
    if (which == 1) bus_reset_event <= 1'b1;
    if (which == 2) sleep_req <= 1'b1;
    link_on_packet_node <= node;
    @(posedge core_clk);
    link_on_packet_valid <= 1'b0;
    bus_reset_event <= 1'b0;
    sleep_req <= 1'b0;
  endtask

  task automatic count_high(input int cycles, output int highs);
    highs = 0;
    repeat (cycles) begin
      @(posedge core_clk);
      #1;
      if (link_wake_output !== 1'b0) highs++;
    end
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (11) @(posedge core_clk);
    #1;
    check({7'h0, link_wake_output_oe_n}, 8'h01);
    check({2'h0, node_number_field}, 8'h2A);
    check({4'h0, priority_field}, 8'h09);
    @(posedge core_clk);
    reset <= 1'b0;
    rd_chk(`PSW_OFS_NODE, 8'h2A);
    rd_chk(`PSW_OFS_PRIO, 8'h09);
    check({6'h0, link_wake_output_oe_n, link_wake_output}, 8'h00);
    node_strap <= 6'h15;
    prio_strap <= 4'h6;
    reg_wr(`PSW_OFS_NODE, 8'h3F);
    reg_wr(`PSW_OFS_PRIO, 8'h03);
    rd_chk(`PSW_OFS_NODE, 8'h3F);
    rd_chk(`PSW_OFS_PRIO, 8'h03);
    rd_chk(4'hF, 8'h00);
    reg_wr(`PSW_OFS_CTRL, 8'h01);
    repeat (2) @(posedge core_clk);
    rd_chk(`PSW_OFS_NODE, 8'h15);
    rd_chk(`PSW_OFS_PRIO, 8'h06);
    for (int s = 0; s < 2; s++) begin
      speed_select_primary <= s[0];
      auto_wake <= (s == 0);
      repeat (3) @(posedge core_clk);
      #1;
      check({7'h0, speed_mode_s50}, 8'(s));
      rd_chk(`PSW_OFS_STAT, 8'(s << `PSW_STAT_S50_BIT) | 8'(1 << `PSW_STAT_LPS_BIT));
      n = sys_clk_out;
      @(posedge core_clk);
      #1;
      check({7'h0, sys_clk_out}, {7'h0, ~n[0]});
      pulse(2, 6'h00);
      repeat (6) @(posedge core_clk);
      #1;
      check({7'h0, lps_active}, 8'h01);
      wait_x(1, 0, 30);
      pulse(0, 6'h14);
      count_high(30, n);
      check(8'(n), 8'h00);
      pulse(0, 6'h15);
      wait_x(0, 1, 4);
      rd_chk(`PSW_OFS_STAT, 8'(s << `PSW_STAT_S50_BIT) | 8'(1 << `PSW_STAT_WAKE_BIT));
      wait_x(0, 0, 40);
      wait_x(0, 1, 40);
      n = 1;
      for (int i = 0; i < 40 && link_wake_output === 1'b1; i++) begin
        @(posedge core_clk);
        #1;
        if (link_wake_output === 1'b1) n++;
      end
      check(8'(n), 8'(s == 0 ? 2 * `PSW_WAKE_HALF_S100 : 2 * `PSW_WAKE_HALF_S50));
      if (s == 0) begin
        wait_x(1, 1, 60);
        wait_x(0, 0, 4);
        pulse(0, 6'h15);
        count_high(30, n);
        check(8'(n), 8'h00);
      end else begin
        pulse(1, 6'h00);
        wait_x(0, 0, 3);
        count_high(30, n);
        check(8'(n), 8'h00);
      end
    end
    for (int k = 0; k < 32; k++) begin
      @(posedge core_clk);
      transceiver_polarity_invert <= k[4];
      {tx_data_core, tx_strobe_core, oc_enable_core, ts_enable_core} <= k[3:0];
      {rx_data_pin, rx_strobe_in} <= k[1:0];
      @(posedge core_clk);
      #1;
      check({4'h0, tx_data_out, tx_strobe_out, open_collector_drive_enable,
             tristate_drive_enable}, {4'h0, k[3:0] ^ {4{k[4]}}});
      check({6'h0, rx_data_core, rx_strobe_core}, {6'h0, k[1:0] ^ {2{k[4]}}});
    end
    rd_chk(`PSW_OFS_STAT, 8'(1 << `PSW_STAT_S50_BIT) | 8'(1 << `PSW_STAT_INV_BIT));
    @(posedge core_clk);
    reset <= 1'b1;
    @(posedge core_clk);
    #1;
    check({7'h0, link_wake_output_oe_n}, 8'h01);
    check({2'h0, node_number_field}, 8'h15);
    finish_test();
  end
endmodule
